//--- design/overexcitation_stage.sv
// Function
// RULE1 - Pick up above nominal plus percentage
// RULE2 - Drop out below 97 percent threshold
// RULE3 - Ratio computed and compared every evaluation
// RULE4 - Alarm after separate definite delay
// RULE5 - Delay type selects DT, inverse, both
// RULE6 - Multiplier used only in inverse modes
// RULE7 - Fixed definite delay in DT modes
// RULE8 - Inverse time formula with exponent
// RULE9 - Start only when not blocked
// RULE10 - Release time holds start for timers
// RULE11 - Delayed release chooses start clearing
// RULE12 - Timer reset after release option
// RULE13 - Timer continues during release option
// RULE14 - No trip unless pick-up returns
// RULE15 - Default 60 ms release, timer held
// RULE16 - Read-only status code
// RULE17 - Expected operating time reported
// RULE18 - Signed remaining time reported
// RULE19 - Nominal, measured and relative ratio reported
// RULE20 - Ratio uses largest phase-to-phase voltage
// RULE21 - Front end updates every 5 ms
// RULE22 - Blocked at pick-up stops timing
// RULE23 - Everything evaluated once per tick
// RULE24 - Combined mode trips on formula time; the code trips on definite delay plus formula time
`timescale 1ns/1ps
`include "ovx_consts.svh"
module overexcitation_stage #(
   parameter int TICK_CYCLES = `OVX_TICK_NS / `OVX_CLK_NS
) (
   input  wire logic             pclk,     // APB clock, 125 MHz
   input  wire logic             presetn,  // Async reset, active low
   input  wire logic             psel,     // APB select
   input  wire logic             penable,  // APB enable
   input  wire logic             pwrite,   // APB direction
   input  wire logic [7:0]       paddr,    // APB byte address
   input  wire logic [31:0]      pwdata,   // APB write data
   output logic      [31:0]      prdata,   // APB read data
   output logic                  pready,   // APB ready
   output logic                  pslverr,  // APB error, unmapped
   input  wire ovx_pkg::meas_t   meas,     // RMS voltages and frequency
   input  wire logic             block_in, // Blocking pin
   output logic                  start,    // Start output
   output logic                  alarm,    // Alarm output
   output logic                  trip,     // Trip output
   output logic                  blocked   // Blocked output
);
   generate
      if (TICK_CYCLES < `OVX_TICK_MIN)
      begin : g_chk
         $error("TICK_CYCLES too small for the ratio engine");
      end
   endgenerate

   localparam int TW = $clog2(TICK_CYCLES);

   ovx_pkg::settings_t  cfg;
   ovx_pkg::eng_state_t state;
   logic [TW-1:0] tick_cnt;
   logic          tick;
   logic [2:0]    blk_sync;
   logic          block_s;
   logic [15:0]   vmax;
   logic [15:0]   freq;
   logic [4:0]    op_idx;
   logic [5:0]    step;
   logic [47:0]   dvd;
   logic [47:0]   dvs;
   logic [48:0]   rem;
   logic [48:0]   rem_sh;
   logic [47:0]   op_dvd;
   logic [47:0]   op_dvs;
   logic [47:0]   res_q;
   logic [4:0]    last_op;
   logic [15:0]   nom_vhz;
   logic [15:0]   meas_vhz;
   logic [15:0]   ratio;
   logic [31:0]   pu;
   logic [31:0]   x_over;
   logic [47:0]   q;
   logic [18:0]   inv_time;
   logic          eval;
   logic          eval_d;
   logic          picked;
   logic          eff;
   logic [18:0]   rel_cnt;
   logic [18:0]   op_cnt;
   logic [18:0]   alm_cnt;
   logic [2:0]    status;
   logic [18:0]   exp_time;
   logic [31:0]   remain;
   logic          next_picked;
   logic          next_blk;
   logic          next_eff;
   logic [18:0]   next_rel_cnt;
   logic          releasing;
   logic          next_start;
   logic [18:0]   next_op_cnt;
   logic [18:0]   next_alm_cnt;
   logic          next_alarm;
   logic          next_trip;
   logic [18:0]   op_time;
   logic [19:0]   both_time;
   logic [47:0]   thr;

   // ----------------------------------------
   // Processing tick and blocking input
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end
      else if (tick_cnt == TW'(TICK_CYCLES - 1))
      begin
         tick_cnt <= '0;
         tick     <= 1'b1;
      end
      else
      begin
         tick_cnt <= tick_cnt + 1'b1;
         tick     <= 1'b0;
      end
   end

   // Pin from another domain: third stage confirms the second
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         blk_sync <= 3'h0;
         block_s  <= 1'b0;
      end
      else
      begin
         blk_sync <= {blk_sync[1:0], block_in};
         if (blk_sync[1] == blk_sync[2])
            block_s <= blk_sync[2];
      end
   end

   // ----------------------------------------
   // Ratio engine: one shared serial divider
   // ----------------------------------------
   assign last_op = `OVX_OP_INV + {1'b0, cfg.inverse_exponent};
   assign x_over  = (48'(pu) > `OVX_PU_ONE) ? (pu - 32'(`OVX_PU_ONE)) : 32'h0;
   assign rem_sh  = {rem[47:0], dvd[47]};

   always_comb
   begin
      op_dvd = q;
      op_dvs = `OVX_HUNDRED;
      unique case (op_idx)
         5'h0:
         begin
            op_dvd = `OVX_MILLION;
            op_dvs = 48'(cfg.fnom);
         end
         5'h1:
         begin
            op_dvd = 48'(vmax) * `OVX_THOUSAND; // RULE3
            op_dvs = 48'(freq);
         end
         5'h2:
         begin
            op_dvd = 48'(vmax) * 48'(cfg.fnom) * `OVX_TEN;
            op_dvs = 48'(freq);
         end
         5'h3:
         begin
            op_dvd = 48'(vmax) * 48'(cfg.fnom);
            op_dvs = 48'(freq);
         end
         default:
         begin
            // Divide by (pu - 1) once per exponent step, then descale
            if (op_idx != last_op)
            begin
               op_dvd = q * `OVX_PU_ONE; // RULE8
               op_dvs = 48'(x_over);
            end
         end
      endcase
   end

   // Zero divisor gives all ones, which the clamps turn into maximum
   assign res_q = dvd;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state  <= ovx_pkg::ENG_IDLE;
         op_idx <= 5'h0;
         step   <= 6'h0;
         dvd    <= '0;
         dvs    <= '0;
         rem    <= '0;
         eval   <= 1'b0;
      end
      else
      begin
         eval <= 1'b0;
         unique case (state)
            ovx_pkg::ENG_IDLE:
               if (tick) // RULE23
               begin
                  op_idx <= 5'h0;
                  state  <= ovx_pkg::ENG_LOAD;
               end
            ovx_pkg::ENG_LOAD:
            begin
               dvd   <= op_dvd;
               dvs   <= op_dvs;
               rem   <= '0;
               step  <= 6'h0;
               state <= ovx_pkg::ENG_DIV;
            end
            ovx_pkg::ENG_DIV:
            begin
               if (rem_sh >= {1'b0, dvs})
               begin
                  rem <= rem_sh - {1'b0, dvs};
                  dvd <= {dvd[46:0], 1'b1};
               end
               else
               begin
                  rem <= rem_sh;
                  dvd <= {dvd[46:0], 1'b0};
               end
               step <= step + 1'b1;
               if (step == `OVX_DIV_LAST)
               begin
                  op_idx <= op_idx + 1'b1;
                  state  <= (op_idx == last_op) ? ovx_pkg::ENG_EVAL : ovx_pkg::ENG_LOAD;
               end
            end
            ovx_pkg::ENG_EVAL:
            begin
               eval  <= 1'b1;
               state <= ovx_pkg::ENG_IDLE;
            end
         endcase
      end
   end

   // Capture reads dvd before the extra final shift disturbs it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vmax     <= 16'h0;
         freq     <= 16'h0;
         q        <= '0;
         nom_vhz  <= 16'h0;
         meas_vhz <= 16'h0;
         ratio    <= 16'h0;
         pu       <= 32'h0;
         inv_time <= 19'h0;
      end
      else if (state == ovx_pkg::ENG_IDLE && tick)
      begin
         // Largest phase-to-phase voltage, sampled with frequency
         vmax <= (meas.v12 > meas.v23) ? ((meas.v12 > meas.v31) ? meas.v12 : meas.v31)
                                       : ((meas.v23 > meas.v31) ? meas.v23 : meas.v31); // RULE20
         freq <= meas.freq;
         q    <= 48'(cfg.time_multiplier) * `OVX_K_SCALE; // RULE8
      end
      else if (state == ovx_pkg::ENG_DIV && step == `OVX_DIV_LAST)
      begin
         unique case (op_idx)
            5'h0: nom_vhz  <= (res_q > 48'hffff) ? 16'hffff : res_q[15:0]; // RULE19
            5'h1: meas_vhz <= (res_q > 48'hffff) ? 16'hffff : res_q[15:0]; // RULE19
            5'h2: pu       <= (res_q > 48'hffff_ffff) ? 32'hffff_ffff : res_q[31:0];
            5'h3: ratio    <= (res_q > 48'hffff) ? 16'hffff : res_q[15:0]; // RULE19
            default:
               if (op_idx == last_op)
                  inv_time <= (res_q > 48'(`OVX_T_MAX)) ? `OVX_T_MAX : res_q[18:0];
               else
                  q <= (res_q > `OVX_Q_MAX) ? `OVX_Q_MAX : res_q;
         endcase
      end
   end

   // ----------------------------------------
   // Comparator, release and timers
   // ----------------------------------------
   assign thr = `OVX_PU_ONE + 48'(cfg.pickup); // RULE1

   always_comb
   begin
      if (picked)
         next_picked = !(48'(pu) * `OVX_HUNDRED < thr * `OVX_RESET_PCT); // RULE2
      else
         next_picked = 48'(pu) > thr; // RULE1
      // Blocked at pick-up moment stays blocked for the whole event
      next_blk = next_picked & (picked ? blocked : block_s); // RULE22
      next_eff = next_picked & !next_blk & !block_s; // RULE9
      if (next_eff)
         next_rel_cnt = 19'h0;
      else if (eff)
         next_rel_cnt = cfg.release_time; // RULE10
      else if (rel_cnt != 19'h0)
         next_rel_cnt = rel_cnt - 1'b1;
      else
         next_rel_cnt = 19'h0;
      releasing  = !next_eff & (next_rel_cnt != 19'h0);
      // A blocked pick-up must not revive a release hold
      next_start = !next_blk & (next_eff | (releasing & cfg.delayed_release)); // RULE11
      if (next_eff || (releasing && cfg.continue_timing)) // RULE13
         next_op_cnt = (op_cnt == `OVX_T_MAX) ? op_cnt : op_cnt + 1'b1;
      else if (releasing && cfg.timer_rst_after_rel) // RULE15
         next_op_cnt = op_cnt;
      else
         next_op_cnt = 19'h0; // RULE12
      next_alm_cnt = !next_eff ? 19'h0 : ((alm_cnt == `OVX_T_MAX) ? alm_cnt : alm_cnt + 1'b1);
      next_alarm   = next_eff & (next_alm_cnt > cfg.alarm_delay); // RULE4
      both_time    = {1'b0, cfg.definite_delay} + {1'b0, inv_time};
      unique case (cfg.delay_type) // RULE5
         ovx_pkg::DLY_DT:   op_time = cfg.definite_delay; // RULE7
         ovx_pkg::DLY_INV:  op_time = inv_time; // RULE6
         ovx_pkg::DLY_BOTH: op_time = (both_time > 20'(`OVX_T_MAX)) ? `OVX_T_MAX
                                                                   : both_time[18:0]; // RULE24
         default:           op_time = cfg.definite_delay;
      endcase
      // Pick-up must be present, not just the release hold
      next_trip = next_eff & (next_op_cnt > op_time); // RULE14
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         picked   <= 1'b0;
         eff      <= 1'b0;
         rel_cnt  <= 19'h0;
         op_cnt   <= 19'h0;
         alm_cnt  <= 19'h0;
         start    <= 1'b0;
         alarm    <= 1'b0;
         trip     <= 1'b0;
         blocked  <= 1'b0;
         status   <= 3'h0;
         exp_time <= 19'h0;
         remain   <= 32'h0;
         eval_d   <= 1'b0;
      end
      else
      begin
         eval_d <= eval;
         if (eval) // RULE23
         begin
            picked   <= next_picked;
            eff      <= next_eff;
            rel_cnt  <= next_rel_cnt;
            op_cnt   <= next_op_cnt;
            alm_cnt  <= next_alm_cnt;
            start    <= next_start; // RULE9
            alarm    <= next_alarm;
            trip     <= next_trip;
            blocked  <= next_blk;
            exp_time <= op_time; // RULE17
            remain   <= 32'(op_time) - 32'(next_op_cnt); // RULE18
            if (next_blk)
               status <= ovx_pkg::COND_BLOCKED; // RULE16
            else if (next_trip)
               status <= ovx_pkg::COND_TRIP;
            else if (next_alarm)
               status <= ovx_pkg::COND_ALARM;
            else if (next_start)
               status <= ovx_pkg::COND_START;
            else
               status <= ovx_pkg::COND_NORMAL;
         end
      end
   end

   // ----------------------------------------
   // APB slave, no wait states
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= psel & !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
         if (psel && !penable)
         begin
            unique case (paddr)
               `OVX_REG_CTRL:      prdata <= {20'h0, cfg.inverse_exponent, 3'h0,
                                              cfg.continue_timing, cfg.timer_rst_after_rel,
                                              cfg.delayed_release, cfg.delay_type};
               `OVX_REG_PICKUP:    prdata <= 32'(cfg.pickup);
               `OVX_REG_ALARM_DLY: prdata <= 32'(cfg.alarm_delay);
               `OVX_REG_DEF_DLY:   prdata <= 32'(cfg.definite_delay);
               `OVX_REG_TMULT:     prdata <= 32'(cfg.time_multiplier);
               `OVX_REG_RELEASE:   prdata <= 32'(cfg.release_time);
               `OVX_REG_FNOM:      prdata <= 32'(cfg.fnom);
               `OVX_REG_STATUS:    prdata <= 32'(status); // RULE16
               `OVX_REG_EXP_TIME:  prdata <= 32'(exp_time); // RULE17
               `OVX_REG_REMAIN:    prdata <= remain; // RULE18
               `OVX_REG_NOM_VHZ:   prdata <= 32'(nom_vhz);
               `OVX_REG_MEAS_VHZ:  prdata <= 32'(meas_vhz);
               `OVX_REG_RATIO:     prdata <= 32'(ratio);
               default:            pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Read-only offsets ignore writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg.delay_type          <= ovx_pkg::DLY_DT;
         cfg.delayed_release     <= 1'b1;
         cfg.timer_rst_after_rel <= 1'b1;
         cfg.continue_timing     <= 1'b0;
         cfg.inverse_exponent    <= `OVX_RST_EXP;
         cfg.pickup              <= `OVX_RST_PICKUP;
         cfg.alarm_delay         <= `OVX_RST_ALARM;
         cfg.definite_delay      <= `OVX_RST_DEF;
         cfg.time_multiplier     <= `OVX_RST_TMULT;
         cfg.release_time        <= `OVX_RST_RELEASE; // RULE15
         cfg.fnom                <= `OVX_RST_FNOM;
      end
      else if (psel && penable && pready && pwrite)
      begin
         unique case (paddr)
            `OVX_REG_CTRL:
            begin
               cfg.delay_type          <= pwdata[`OVX_CTRL_TYPE];
               cfg.delayed_release     <= pwdata[`OVX_CTRL_DLYREL];
               cfg.timer_rst_after_rel <= pwdata[`OVX_CTRL_TMRRST];
               cfg.continue_timing     <= pwdata[`OVX_CTRL_CONT];
               cfg.inverse_exponent    <= pwdata[`OVX_CTRL_EXP];
            end
            `OVX_REG_PICKUP:    cfg.pickup          <= pwdata[15:0];
            `OVX_REG_ALARM_DLY: cfg.alarm_delay     <= pwdata[18:0];
            `OVX_REG_DEF_DLY:   cfg.definite_delay  <= pwdata[18:0];
            `OVX_REG_TMULT:     cfg.time_multiplier <= pwdata[15:0];
            `OVX_REG_RELEASE:   cfg.release_time    <= pwdata[18:0];
            `OVX_REG_FNOM:      cfg.fnom            <= pwdata[15:0];
            default:
            begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_start_unblocked: assert property (start |-> !blocked) // RULE9
      else $error("start with blocked");
   a_trip_needs_pickup: assert property ($rose(trip) |-> eff && start) // RULE14
      else $error("trip without pick-up");
   a_alarm_delay_met: assert property ($rose(alarm) |-> alm_cnt > cfg.alarm_delay) // RULE4
      else $error("alarm before delay");
   a_status_trip: assert property (trip |-> status == 3'h3) // RULE16
      else $error("status not trip");
   a_instant_release: assert property (eval_d && !cfg.delayed_release |-> start == eff) // RULE11
      else $error("start held without delayed release");
   a_pickup_hold: assert property ( // RULE2
      eval && picked && !(48'(pu) * `OVX_HUNDRED < thr * `OVX_RESET_PCT) |=> picked)
      else $error("pick-up dropped above reset level");
   a_dt_time: assert property ( // RULE7
      eval && cfg.delay_type == 2'h0 |=> exp_time == cfg.definite_delay)
      else $error("definite time not used");
   a_eval_spacing: assert property (eval |=> !eval [*8]) // RULE23
      else $error("evaluation too frequent");
   a_timer_clear: assert property ( // RULE12
      eval && eff && !next_eff && !cfg.timer_rst_after_rel && !cfg.continue_timing
      |=> op_cnt == 19'h0)
      else $error("timer not cleared at drop");
endmodule

//--- design/ovx_consts.svh
`ifndef OVX_CONSTS_SVH
`define OVX_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OVX_REG_CTRL      8'h00
`define OVX_REG_PICKUP    8'h04
`define OVX_REG_ALARM_DLY 8'h08
`define OVX_REG_DEF_DLY   8'h0c
`define OVX_REG_TMULT     8'h10
`define OVX_REG_RELEASE   8'h14
`define OVX_REG_FNOM      8'h18
`define OVX_REG_STATUS    8'h1c
`define OVX_REG_EXP_TIME  8'h20
`define OVX_REG_REMAIN    8'h24
`define OVX_REG_NOM_VHZ   8'h28
`define OVX_REG_MEAS_VHZ  8'h2c
`define OVX_REG_RATIO     8'h30
// ----------------------------------------
// Control fields
// ----------------------------------------
`define OVX_CTRL_TYPE     1:0
`define OVX_CTRL_DLYREL   2
`define OVX_CTRL_TMRRST   3
`define OVX_CTRL_CONT     4
`define OVX_CTRL_EXP      11:8
// ----------------------------------------
// Reset values and scaling
// ----------------------------------------
`define OVX_RST_PICKUP    16'h01f4
`define OVX_RST_ALARM     19'h00008
`define OVX_RST_DEF       19'h00008
`define OVX_RST_TMULT     16'h0001
`define OVX_RST_RELEASE   19'h0000c
`define OVX_RST_FNOM      16'hc350
`define OVX_RST_EXP       4'h1
`define OVX_PU_ONE        48'h0000_0000_2710
`define OVX_RESET_PCT     48'h0000_0000_0061
`define OVX_HUNDRED       48'h0000_0000_0064
`define OVX_TEN           48'h0000_0000_000a
`define OVX_THOUSAND      48'h0000_0000_03e8
`define OVX_MILLION       48'h0000_000f_4240
`define OVX_K_SCALE       48'h0000_0000_0024
`define OVX_Q_MAX         48'h0000_0225_5100
`define OVX_T_MAX         19'h57e40
`define OVX_TICK_NS       5000000
`define OVX_CLK_NS        8
`define OVX_TICK_MIN      1024
`define OVX_DIV_LAST      6'h30
`define OVX_OP_INV        5'h4
`endif

//--- design/ovx_pkg.sv
package ovx_pkg;
   typedef enum logic [3:0] {
      ENG_IDLE = 4'b0001,
      ENG_LOAD = 4'b0010,
      ENG_DIV  = 4'b0100,
      ENG_EVAL = 4'b1000
   } eng_state_t;
   typedef enum logic [1:0] {
      DLY_DT   = 2'h0,
      DLY_INV  = 2'h1,
      DLY_BOTH = 2'h2
   } delay_type_t;
   typedef enum logic [2:0] {
      COND_NORMAL  = 3'h0,
      COND_START   = 3'h1,
      COND_ALARM   = 3'h2,
      COND_TRIP    = 3'h3,
      COND_BLOCKED = 3'h4
   } cond_t;
   typedef struct packed {
      logic [1:0]  delay_type;
      logic        delayed_release;
      logic        timer_rst_after_rel;
      logic        continue_timing;
      logic [3:0]  inverse_exponent;
      logic [15:0] pickup;
      logic [18:0] alarm_delay;
      logic [18:0] definite_delay;
      logic [15:0] time_multiplier;
      logic [18:0] release_time;
      logic [15:0] fnom;
   } settings_t;
   typedef struct packed {
      logic [15:0] v12;
      logic [15:0] v23;
      logic [15:0] v31;
      logic [15:0] freq;
   } meas_t;
endpackage

//--- sim/ovx_front_end.sv
`timescale 1ns/1ps
module ovx_front_end #(
   parameter int TICK = 1024
) (
   input  wire logic           pclk,       // Clock
   input  wire logic           presetn,    // Reset, active low
   input  wire ovx_pkg::meas_t next_meas,  // Values for next update
   input  wire logic           next_block, // Blocking request
   output ovx_pkg::meas_t      meas,       // Published measurement
   output logic                block_in    // Blocking pin
);
   int cnt;
   // ----------------------------------------
   // Publish measurement once per update period, blocking pin every clock
   // ----------------------------------------
   // Not aligned to the stage's own tick on purpose
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt      <= 0;
         meas     <= '0;
         block_in <= 1'b0;
      end
      else
      begin
         block_in <= next_block;
         cnt      <= (cnt == TICK - 1) ? 0 : cnt + 1;
         if (cnt == 0)
            meas <= next_meas;
      end
endmodule

//--- sim/overexcitation_stage_tb.sv
`timescale 1ns/1ps
module overexcitation_stage_tb;
   localparam int T = 1024;
   logic           pclk    = 1'b0;
   logic           presetn = 1'b0;
   logic           psel    = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite  = 1'b0;
   logic [7:0]     paddr   = 8'h00;
   logic [31:0]    pwdata  = 32'h0;
   logic           nb      = 1'b0;
   ovx_pkg::meas_t nm      = {16'h03e8, 16'h03e8, 16'h03e8, 16'hc350};
   ovx_pkg::meas_t meas;
   logic [31:0]    prdata, rd;
   logic           pready, pslverr, start, alarm, trip, blocked, block_in, er;
   int             fails = 0, n_compared = 0, cyc = 0, seed = 32'hd291, n, m;

   always #4 pclk = ~pclk;

   overexcitation_stage #(.TICK_CYCLES(T)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
      .block_in(block_in), .start(start), .alarm(alarm), .trip(trip), .blocked(blocked));
   ovx_front_end #(.TICK(T)) fe (.pclk(pclk), .presetn(presetn), .next_meas(nm),
      .next_block(nb), .meas(meas), .block_in(block_in));

   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Hang guard, about twice the expected run
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         fails++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Cycles until output s reaches level v
   task automatic wait_on(input int s, input logic v);
      logic x;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
         x = s == 0 ? start : s == 1 ? alarm : s == 2 ? trip : blocked;
      end
      while (x !== v && n < 20 * T);
   endtask

   // Largest voltage on a random phase, others lower
   task automatic set_v(input logic [15:0] v);
      logic [15:0] lo;
      int          r;
      lo = 16'($unsigned($random(seed)) % v);
      r  = $unsigned($random(seed)) % 3;
      nm.v12  <= r == 0 ? v : lo;
      nm.v23  <= r == 1 ? v : lo;
      nm.v31  <= r == 2 ? v : lo;
      nm.freq <= 16'hc350;
   endtask

   // Relative ratio in 0.001 units against the 50 Hz nominal
   function automatic logic [31:0] ratio_exp(input logic [15:0] v, input logic [15:0] f);
      return 32'(v) * 32'h0000c350 / 32'(f);
   endfunction

   // Inverse operate ticks: 0.36 * k / (pu - 1)^e, v in 0.001 per-unit
   function automatic int inv_exp(input int k, input int v, input int e);
      longint q;
      q = 36 * k;
      for (int i = 0; i < e; i++)
         q = q * 10000 / (v * 10 - 10000);
      return int'(q / 100);
   endfunction

   initial
   begin
      logic [31:0] dflt [8] = '{32'h10c, 32'h1f4, 32'h8, 32'h8, 32'h1, 32'hc, 32'hc350, 32'h0};
      logic [15:0] v;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(rd, dflt[i]);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 8'h1c, 32'h3);
      apb(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h0);
      $display("Registers done");
      for (int i = 0; i < 4; i++)
      begin
         v = 16'(900 + $unsigned($random(seed)) % 141);
         set_v(v);
         repeat (3 * T) @(posedge pclk);
         apb(1'b0, 8'h30, 32'h0);
         chk(rd, ratio_exp(v, 16'hc350));
         chk({31'h0, start}, 32'h0);
      end
      $display("Ratio done");
      apb(1'b1, 8'h08, 32'h4);
      apb(1'b1, 8'h10, 32'h1964);
      set_v(16'h044c);
      wait_on(0, 1'b1);
      wait_on(1, 1'b1);
      m = n;
      wait_on(2, 1'b1);
      chk(m, 4 * T);
      chk(m + n, 8 * T);
      apb(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h3);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h8);
      $display("Definite trip done");
      set_v(16'h03e8);
      wait_on(0, 1'b0);
      chk(n > 12 * T && n < 15 * T, 32'h1);
      $display("Release done");
      apb(1'b1, 8'h10, 32'h1);
      apb(1'b1, 8'h00, 32'h101);
      set_v(16'h044c);
      wait_on(0, 1'b1);
      wait_on(2, 1'b1);
      chk(n, inv_exp(1, 1100, 1) * T);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, inv_exp(1, 1100, 1));
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, 32'hffff_ffff);
      set_v(16'h03e8);
      wait_on(0, 1'b0);
      chk({31'h0, trip}, 32'h0);
      chk(n < 3 * T, 32'h1);
      apb(1'b1, 8'h00, 32'h102);
      $display("Inverse done");
      nb <= 1'b1;
      set_v(16'h044c);
      wait_on(3, 1'b1);
      chk({31'h0, blocked}, 32'h1);
      chk({31'h0, start}, 32'h0);
      apb(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'(8 + inv_exp(1, 1100, 1)));
      $display("Blocking done");
      print_verdict();
   end
endmodule
